// ==== pkg/acp_pkg.sv ====
package acp_pkg;
  // byte i/o port addresses
  localparam logic [15:0] ACP_PORT_ATTR_WR   = 16'h03c0;
  localparam logic [15:0] ACP_PORT_ATTR_RD   = 16'h03c1;
  localparam logic [15:0] ACP_PORT_INPUT_STATUS_ONE_MONO = 16'h03ba;
  localparam logic [15:0] ACP_PORT_INPUT_STATUS_ONE_CLR  = 16'h03da;
  // register indices
  localparam logic [4:0]  ACP_IDX_PAL_LAST   = 5'h0f;
  localparam logic [4:0]  ACP_IDX_MODE       = 5'h10;
  localparam logic [4:0]  ACP_IDX_BORDER     = 5'h11;
  localparam logic [4:0]  ACP_IDX_PLANE      = 5'h12;
  localparam logic [4:0]  ACP_IDX_PAN        = 5'h13;
  localparam logic [4:0]  ACP_IDX_COLSEL     = 5'h14;
  // field positions
  localparam int          ACP_IDX_VIDEO_EN   = 5;
  localparam int          ACP_MODE_P54_SEL   = 7;
  localparam int          ACP_MODE_8BIT      = 6;
  localparam int          ACP_MODE_PAN_UPPER = 5;
  localparam int          ACP_MODE_BLINK     = 3;
  localparam int          ACP_MODE_LINE_GFX  = 2;
  localparam int          ACP_MODE_MONO      = 1;
  localparam int          ACP_MODE_GFX       = 0;
  // read masks and reset values
  localparam logic [7:0]  ACP_MODE_RD_MASK   = 8'hef;
  localparam logic [7:0]  ACP_RST_REG8       = 8'h00;
  localparam logic [5:0]  ACP_RST_REG6       = 6'h00;
  localparam logic [3:0]  ACP_RST_REG4       = 4'h0;
  // line drawing character range
  localparam logic [7:0]  ACP_LINE_GFX_LO    = 8'hb0;
  localparam logic [7:0]  ACP_LINE_GFX_HI    = 8'hdf;
  // timing
  localparam int          ACP_DOT_DIV        = 4;
  localparam int          ACP_BLINK_DIV      = 16;

  typedef enum logic {ACP_FF_INDEX, ACP_FF_DATA} acp_ff_t;
  typedef enum logic {ACP_PH_HIGH, ACP_PH_LOW} acp_phase_t;
endpackage

// ==== verilog/acp_pixel_map.sv ====
`timescale 1ns/1ns
module acp_pixel_map
  import acp_pkg::*;
(
  input  wire logic [3:0] color_in,
  input  wire logic [5:0] map_entry,
  input  wire logic [3:0] color_select,
  input  wire logic       p54_from_select,
  output logic      [7:0] palette_index
);
  always_comb
  begin
    palette_index[7:6] = color_select[3:2];
    palette_index[5:4] = p54_from_select ? color_select[1:0] : map_entry[5:4];
    palette_index[3:0] = map_entry[3:0];
    if (color_in == 4'h0 && map_entry == 6'h00)
    begin
      palette_index[3:0] = 4'h0;
    end
  end
endmodule

// ==== verilog/acp_top.sv ====
// What this block does
// - each write to the shared port alternates between storing index and storing data
// - status register one read, at the mono or colour address chosen by misc_color_emul, forces the index state
// - data read port returns indexed register, flip-flop state unchanged
// - reading the shared write port returns the index register
// - index bits 4:0 select register 00h-14h; bits 7:6 read zero
// - video enable clear forces colour index 00h in the active area, timing continues
// - video enable set blocks host access to the sixteen palette entries
// - each palette entry supplies index bits 5:0; bits 7:6 read zero
// - colour select bits 3:2 supply index bits 7:6, except in 8-bit mode where the first nibble does
// - mode bit 7 takes index bits 5:4 from colour select bits 1:0
// - mode bit 6 joins two nibbles into 8 bits every other dot
// - mode bit 5 restricts panning to the upper region
// - mode bit 3 picks blinking or background intensity; blink divides vsync
// - mode bit 2 copies the eighth pixel into the ninth for B0h-DFh
// - mode bit 1 decodes text attributes for monochrome display
// - mode bit 0 selects text or graphics, kept consistent by software
// - border register gives the index output in the overscan region
// - plane register bits 5:4 route two palette bits to status bits 5:4
// - plane register bits 3:0 gate each plane, disabled plane reads zero
`timescale 1ns/1ns
module acp_top
  import acp_pkg::*;
#(
  parameter int DOT_DIV   = ACP_DOT_DIV,
  parameter int BLINK_DIV = ACP_BLINK_DIV
)
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  input  wire logic        misc_color_emul,
  input  wire logic [3:0]  plane_bits,
  input  wire logic [7:0]  text_attr,
  input  wire logic [7:0]  char_code,
  input  wire logic        glyph_bit,
  input  wire logic        ninth_col,
  input  wire logic        video_active,
  input  wire logic        border_active,
  input  wire logic        vsync_pulse,
  input  wire logic        in_lower_region,
  output logic             dot_en,
  output logic      [7:0]  pix_index,
  output logic             pix_valid,
  output logic      [3:0]  pan_shift,
  output logic      [1:0]  status_mux_bits,
  output logic             gfx_mode,
  output logic             line_gfx_en
);
  if (DOT_DIV < 1 || DOT_DIV > 255 || BLINK_DIV < 1 || BLINK_DIV > 255)
  begin
    $error("acp_top: divider parameter out of range");
  end

  acp_ff_t    port_ff;
  acp_ff_t    next_port_ff;
  logic [4:0] index;
  logic [4:0] next_index;
  logic       video_en;
  logic       next_video_en;
  logic [5:0] pal [16];
  logic [5:0] next_pal [16];
  logic [7:0] mode;
  logic [7:0] next_mode;
  logic [7:0] border;
  logic [7:0] next_border;
  logic [5:0] plane;
  logic [5:0] next_plane;
  logic [3:0] pan;
  logic [3:0] next_pan;
  logic [3:0] colsel;
  logic [3:0] next_colsel;
  logic [7:0] next_io_rdata;
  logic       pal_we;
  logic [7:0] reg_view;
  logic       input_status_one_rd;

  assign input_status_one_rd = io_rd &&
                   (io_addr == (misc_color_emul ? ACP_PORT_INPUT_STATUS_ONE_CLR : ACP_PORT_INPUT_STATUS_ONE_MONO));
  assign pal_we  = io_wr && io_addr == ACP_PORT_ATTR_WR && port_ff == ACP_FF_DATA &&
                   index <= ACP_IDX_PAL_LAST && !video_en;

  always_comb
  begin
    reg_view = 8'h00;
    if (index <= ACP_IDX_PAL_LAST)
    begin
      reg_view = video_en ? 8'h00 : {2'b00, pal[index[3:0]]};
    end
    else
    begin
      case (index)
        ACP_IDX_MODE:   reg_view = mode & ACP_MODE_RD_MASK;
        ACP_IDX_BORDER: reg_view = border;
        ACP_IDX_PLANE:  reg_view = {2'b00, plane};
        ACP_IDX_PAN:    reg_view = {4'h0, pan};
        ACP_IDX_COLSEL: reg_view = {4'h0, colsel};
        default:        reg_view = 8'h00;
      endcase
    end
  end

  always_comb
  begin
    next_port_ff  = port_ff;
    next_index    = index;
    next_video_en = video_en;
    next_pal      = pal;
    next_mode     = mode;
    next_border   = border;
    next_plane    = plane;
    next_pan      = pan;
    next_colsel   = colsel;
    next_io_rdata = io_rdata;
    if (io_wr && io_addr == ACP_PORT_ATTR_WR)
    begin
      if (port_ff == ACP_FF_INDEX)
      begin
        next_index    = io_wdata[4:0];
        next_video_en = io_wdata[ACP_IDX_VIDEO_EN];
        next_port_ff  = ACP_FF_DATA;
      end
      else
      begin
        next_port_ff = ACP_FF_INDEX;
        if (pal_we)
        begin
          next_pal[index[3:0]] = io_wdata[5:0];
        end
        case (index)
          ACP_IDX_MODE:   next_mode   = io_wdata & ACP_MODE_RD_MASK;
          ACP_IDX_BORDER: next_border = io_wdata;
          ACP_IDX_PLANE:  next_plane  = io_wdata[5:0];
          ACP_IDX_PAN:    next_pan    = io_wdata[3:0];
          ACP_IDX_COLSEL: next_colsel = io_wdata[3:0];
          default:        next_mode   = mode;
        endcase
      end
    end
    if (io_rd)
    begin
      if (io_addr == ACP_PORT_ATTR_WR)
      begin
        next_io_rdata = {2'b00, video_en, index};
      end
      else if (io_addr == ACP_PORT_ATTR_RD)
      begin
        next_io_rdata = reg_view;
      end
      else
      begin
        next_io_rdata = 8'h00;
      end
      if (input_status_one_rd)
      begin
        next_port_ff = ACP_FF_INDEX;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      port_ff  <= ACP_FF_INDEX;
      index    <= 5'h00;
      video_en <= 1'b0;
      pal      <= '{default: ACP_RST_REG6};
      mode     <= ACP_RST_REG8;
      border   <= ACP_RST_REG8;
      plane    <= ACP_RST_REG6;
      pan      <= ACP_RST_REG4;
      colsel   <= ACP_RST_REG4;
      io_rdata <= ACP_RST_REG8;
    end
    else
    begin
      port_ff  <= next_port_ff;
      index    <= next_index;
      video_en <= next_video_en;
      pal      <= next_pal;
      mode     <= next_mode;
      border   <= next_border;
      plane    <= next_plane;
      pan      <= next_pan;
      colsel   <= next_colsel;
      io_rdata <= next_io_rdata;
    end
  end

  // pixel side
  logic [7:0] dot_cnt;
  logic [7:0] next_dot_cnt;
  logic [7:0] blink_cnt;
  logic [7:0] next_blink_cnt;
  logic       blink_on;
  logic       next_blink_on;
  logic       last_glyph;
  logic       next_last_glyph;
  acp_phase_t phase;
  acp_phase_t next_phase;
  logic [3:0] high_nib;
  logic [3:0] next_high_nib;
  logic [7:0] next_pix_index;
  logic       next_pix_valid;
  logic [3:0] color;
  logic       fg;
  logic       line_code;
  logic [7:0] mapped;

  assign gfx_mode    = mode[ACP_MODE_GFX];
  assign line_gfx_en = mode[ACP_MODE_LINE_GFX];
  assign pan_shift   = (mode[ACP_MODE_PAN_UPPER] && in_lower_region) ? 4'h0 : pan;
  assign dot_en      = (dot_cnt == 8'(DOT_DIV - 1));
  assign line_code   = char_code >= ACP_LINE_GFX_LO && char_code <= ACP_LINE_GFX_HI;

  always_comb
  begin
    fg = glyph_bit;
    if (ninth_col)
    begin
      fg = (mode[ACP_MODE_LINE_GFX] && line_code) ? last_glyph : 1'b0;
    end
    if (mode[ACP_MODE_BLINK] && text_attr[7] && !blink_on)
    begin
      fg = 1'b0;
    end
    if (mode[ACP_MODE_GFX])
    begin
      color = plane_bits & plane[3:0];
      if (mode[ACP_MODE_BLINK] && !blink_on)
      begin
        color[3] = 1'b0;
      end
    end
    else if (mode[ACP_MODE_MONO])
    begin
      color = fg ? {text_attr[3], 3'b111} : 4'h0;
    end
    else
    begin
      color = fg ? text_attr[3:0]
                 : {text_attr[7] & ~mode[ACP_MODE_BLINK], text_attr[6:4]};
    end
  end

  acp_pixel_map u_map
  (
    .color_in        (color),
    .map_entry       (pal[color]),
    .color_select    (colsel),
    .p54_from_select (mode[ACP_MODE_P54_SEL]),
    .palette_index   (mapped)
  );

  always_comb
  begin
    next_dot_cnt    = dot_en ? 8'h00 : 8'(dot_cnt + 8'h01);
    next_blink_cnt  = blink_cnt;
    next_blink_on   = blink_on;
    next_last_glyph = last_glyph;
    next_phase      = phase;
    next_high_nib   = high_nib;
    next_pix_index  = pix_index;
    next_pix_valid  = 1'b0;
    if (vsync_pulse)
    begin
      next_blink_cnt = 8'(blink_cnt + 8'h01);
      if (blink_cnt == 8'(BLINK_DIV - 1))
      begin
        next_blink_cnt = 8'h00;
        next_blink_on  = ~blink_on;
      end
    end
    if (dot_en)
    begin
      next_last_glyph = ninth_col ? last_glyph : glyph_bit;
      if (border_active)
      begin
        next_pix_index = border;
        next_pix_valid = 1'b1;
        next_phase     = ACP_PH_HIGH;
      end
      else if (!video_active)
      begin
        next_phase = ACP_PH_HIGH;
      end
      else if (!video_en)
      begin
        next_pix_index = 8'h00;
        next_pix_valid = 1'b1;
        next_phase     = ACP_PH_HIGH;
      end
      else if (mode[ACP_MODE_8BIT])
      begin
        case (phase)
          ACP_PH_HIGH:
          begin
            next_high_nib = color;
            next_phase    = ACP_PH_LOW;
          end
          ACP_PH_LOW:
          begin
            next_pix_index = {high_nib, color};
            next_pix_valid = 1'b1;
            next_phase     = ACP_PH_HIGH;
          end
          default:
          begin
            next_phase = ACP_PH_HIGH;
          end
        endcase
      end
      else
      begin
        next_pix_index = mapped;
        next_pix_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      dot_cnt    <= 8'h00;
      blink_cnt  <= 8'h00;
      blink_on   <= 1'b1;
      last_glyph <= 1'b0;
      phase      <= ACP_PH_HIGH;
      high_nib   <= 4'h0;
      pix_index  <= 8'h00;
      pix_valid  <= 1'b0;
    end
    else
    begin
      dot_cnt    <= next_dot_cnt;
      blink_cnt  <= next_blink_cnt;
      blink_on   <= next_blink_on;
      last_glyph <= next_last_glyph;
      phase      <= next_phase;
      high_nib   <= next_high_nib;
      pix_index  <= next_pix_index;
      pix_valid  <= next_pix_valid;
    end
  end

  always_comb
  begin
    case (plane[5:4])
      2'b00:   status_mux_bits = {pix_index[2], pix_index[0]};
      2'b01:   status_mux_bits = {pix_index[5], pix_index[4]};
      2'b10:   status_mux_bits = {pix_index[3], pix_index[1]};
      default: status_mux_bits = {pix_index[7], pix_index[6]};
    endcase
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_toggle;
    io_wr && io_addr == ACP_PORT_ATTR_WR && !io_rd |=> port_ff != $past(port_ff);
  endproperty
  a_toggle: assert property (p_toggle) else $error("shared port did not toggle");

  property p_input_status_one;
    input_status_one_rd |=> port_ff == ACP_FF_INDEX;
  endproperty
  a_input_status_one: assert property (p_input_status_one) else $error("status read kept data state");

  property p_rd_keep;
    io_rd && io_addr == ACP_PORT_ATTR_RD && !io_wr |=> $stable(port_ff);
  endproperty
  a_rd_keep: assert property (p_rd_keep) else $error("data read moved flip-flop");

  property p_idx_rd;
    io_rd && io_addr == ACP_PORT_ATTR_WR |=> io_rdata == {2'b00, $past(video_en), $past(index)};
  endproperty
  a_idx_rd: assert property (p_idx_rd) else $error("index read wrong");

  property p_blank;
    dot_en && video_active && !border_active && !video_en |=> pix_index == 8'h00 && pix_valid;
  endproperty
  a_blank: assert property (p_blank) else $error("disabled video not zero");

  property p_pal_block;
    video_en && io_wr && io_addr == ACP_PORT_ATTR_WR && port_ff == ACP_FF_DATA &&
    index <= ACP_IDX_PAL_LAST |=> pal[index[3:0]] == $past(pal[index[3:0]]);
  endproperty
  a_pal_block: assert property (p_pal_block) else $error("palette written while locked");

  property p_border;
    dot_en && border_active |=> pix_index == $past(border) ##1 !pix_valid;
  endproperty
  a_border: assert property (p_border) else $error("border colour wrong");

  property p_pair;
    dot_en && video_active && !border_active && video_en && mode[ACP_MODE_8BIT] &&
    phase == ACP_PH_HIGH |=> !pix_valid && phase == ACP_PH_LOW;
  endproperty
  a_pair: assert property (p_pair) else $error("8-bit path output early");

  property p_status;
    plane[5:4] == 2'b11 |-> status_mux_bits == pix_index[7:6];
  endproperty
  a_status: assert property (p_status) else $error("status mux wrong");
endmodule

// ==== verification/acp_host_model.sv ====
`timescale 1ns/1ns
module acp_host_model
(
  input  wire logic        mclk,
  output logic      [15:0] io_addr,
  output logic             io_wr,
  output logic             io_rd,
  output logic      [7:0]  io_wdata,
  output logic             misc_color_emul
);
  initial
  begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
    misc_color_emul = 1'b1;
  end

  task automatic emul(input logic m);
    misc_color_emul = m;
  endtask

  // one strobe cycle; released bus shows inverted values
  task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(negedge mclk);
    io_addr = a;
    io_wr = w;
    io_rd = !w;
    io_wdata = d;
    @(negedge mclk);
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    acc(a, 1'b1, d);
  endtask

  task automatic rd(input logic [15:0] a);
    acc(a, 1'b0, 8'h00);
  endtask
endmodule

// ==== verification/acp_testbench.sv ====
`timescale 1ns/1ns
module testbench
  import acp_pkg::*;
();
  logic        mclk;
  logic        resetn;
  wire  [15:0] io_addr;
  wire         io_wr;
  wire         io_rd;
  wire  [7:0]  io_wdata;
  wire         misc_color_emul;
  logic [7:0]  io_rdata;
  logic [3:0]  plane_bits;
  logic [7:0]  text_attr;
  logic [7:0]  char_code;
  logic        glyph_bit;
  logic        ninth_col;
  logic        video_active;
  logic        border_active;
  logic        vsync_pulse;
  logic        in_lower_region;
  logic        dot_en;
  logic [7:0]  pix_index;
  logic        pix_valid;
  logic [3:0]  pan_shift;
  logic [1:0]  status_mux_bits;
  logic        gfx_mode;
  logic        line_gfx_en;
  logic        rd_seen;
  logic [7:0]  rq[$];
  logic [7:0]  pq[$];
  logic [5:0]  pal[16];
  int          n_mismatch;
  int          total_checks;

  acp_top #(.DOT_DIV(2), .BLINK_DIV(1)) uut
  (
    .mclk, .resetn, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
    .misc_color_emul, .plane_bits, .text_attr, .char_code, .glyph_bit,
    .ninth_col, .video_active, .border_active, .vsync_pulse,
    .in_lower_region, .dot_en, .pix_index, .pix_valid, .pan_shift,
    .status_mux_bits, .gfx_mode, .line_gfx_en
  );

  acp_host_model host
  (
    .mclk, .io_addr, .io_wr, .io_rd, .io_wdata, .misc_color_emul
  );

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // watcher: oldest note against each read and pixel
  always @(posedge mclk) rd_seen <= io_rd;
  always @(negedge mclk)
  begin
    if (rd_seen === 1'b1 && rq.size() > 0)
      chk("io_rdata", io_rdata, rq.pop_front());
    if (pix_valid === 1'b1)
      chk("pix_index", pix_index, pq.size() > 0 ? pq.pop_front() : 8'hxx);
  end

  task automatic done(input string nm);
    repeat (3) @(negedge mclk);
    chk("pending", 8'(rq.size() + pq.size()), 8'h00);
    $display("test %s done", nm);
  endtask

  // status read returns the shared port to index state
  task automatic sync;
    rq.push_back(8'h00);
    host.rd(misc_color_emul ? ACP_PORT_INPUT_STATUS_ONE_CLR : ACP_PORT_INPUT_STATUS_ONE_MONO);
  endtask

  task automatic wi(input logic [7:0] idx, input logic [7:0] d);
    sync();
    host.wr(ACP_PORT_ATTR_WR, idx);
    host.wr(ACP_PORT_ATTR_WR, d);
  endtask

  task automatic reg_rd(input logic [7:0] idx, input logic [7:0] e);
    sync();
    host.wr(ACP_PORT_ATTR_WR, idx);
    rq.push_back(e);
    host.rd(ACP_PORT_ATTR_RD);
  endtask

  // stops on the negedge ahead of a dot enable edge
  task automatic wait_dot;
    int k;
    k = 0;
    @(negedge mclk);
    while (dot_en !== 1'b1 && k < 9)
    begin
      @(negedge mclk);
      k++;
    end
    if (k == 9)
    begin
      n_mismatch++;
      summarize();
    end
  endtask

  // two nibbles on consecutive dots, one output expected
  task automatic px8(input logic [3:0] hi, input logic [3:0] lo);
    pq.push_back({hi, lo});
    wait_dot();
    plane_bits = hi;
    video_active = 1'b1;
    wait_dot();
    plane_bits = lo;
    @(negedge mclk);
    video_active = 1'b0;
    repeat (2) @(negedge mclk);
  endtask

  task automatic px(input logic [3:0] b, input logic brd, input logic [7:0] e);
    wait_dot();
    plane_bits = b;
    video_active = !brd;
    border_active = brd;
    pq.push_back(e);
    @(negedge mclk);
    video_active = 1'b0;
    border_active = 1'b0;
    repeat (2) @(negedge mclk);
  endtask

  function automatic logic [1:0] smux(input int s, input logic [7:0] e);
    case (s)
      0: return {e[2], e[0]};
      1: return {e[5], e[4]};
      2: return {e[3], e[1]};
      default: return {e[7], e[6]};
    endcase
  endfunction

  initial
  begin
    logic [3:0] b;
    logic [3:0] c;
    logic [7:0] e;
    logic [7:0] a;
    resetn = 1'b0;
    {plane_bits, text_attr, char_code, glyph_bit, ninth_col} = '0;
    {video_active, border_active, vsync_pulse, in_lower_region} = '0;
    n_mismatch = 0;
    total_checks = 0;
    e = 8'($urandom(2483));
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    host.wr(ACP_PORT_ATTR_WR, 8'h10);
    host.wr(ACP_PORT_ATTR_WR, 8'hff);
    host.wr(ACP_PORT_ATTR_WR, 8'h30);
    rq.push_back(8'hff & ACP_MODE_RD_MASK);
    host.rd(ACP_PORT_ATTR_RD);
    host.wr(ACP_PORT_ATTR_WR, 8'h41);
    rq.push_back(8'h41);
    host.rd(ACP_PORT_ATTR_RD);
    rq.push_back(8'h30);
    host.rd(ACP_PORT_ATTR_WR);
    host.wr(ACP_PORT_ATTR_WR, 8'hd2);
    rq.push_back(8'h12);
    host.rd(ACP_PORT_ATTR_WR);
    done("index data");
    for (int i = 0; i < 16; i++)
    begin
      pal[i] = 6'($urandom);
      wi(8'(i), {2'b11, pal[i]});
      reg_rd(8'(i), {2'b00, pal[i]});
    end
    wi(8'h25, 8'h3f);
    reg_rd(8'h25, 8'h00);
    reg_rd(8'h05, {2'b00, pal[5]});
    wi(8'h15, 8'haa);
    reg_rd(8'h15, 8'h00);
    done("palette");
    for (int m = 0; m < 2; m++)
    begin
      host.emul(m[0]);
      sync();
      host.wr(ACP_PORT_ATTR_WR, 8'h11);
      sync();
      host.wr(ACP_PORT_ATTR_WR, 8'h13);
      rq.push_back(8'h13);
      host.rd(ACP_PORT_ATTR_WR);
    end
    done("status reset");
    c = 4'($urandom);
    wi(8'h14, {4'h0, c});
    wi(8'h10, 8'h01);
    for (int s = 0; s < 4; s++)
    begin
      wi(8'h32, {2'b00, 2'(s), 4'hf});
      b = 4'($urandom);
      e = {c[3:2], pal[b]};
      px(b, 1'b0, e);
      chk("status_mux", {6'h00, status_mux_bits}, {6'h00, smux(s, e)});
    end
    chk("gfx_mode", {7'h00, gfx_mode}, 8'h01);
    wi(8'h30, 8'h85);
    px(b, 1'b0, {c, pal[b][3:0]});
    chk("line_gfx_en", {7'h00, line_gfx_en}, 8'h01);
    wi(8'h32, 8'h05);
    px(4'hf, 1'b0, {c, pal[5][3:0]});
    e = 8'($urandom);
    wi(8'h31, e);
    px(4'h0, 1'b1, e);
    wi(8'h33, 8'h07);
    wi(8'h30, 8'h21);
    in_lower_region = 1'b1;
    @(negedge mclk);
    chk("pan_shift", {4'h0, pan_shift}, 8'h00);
    in_lower_region = 1'b0;
    @(negedge mclk);
    chk("pan_shift", {4'h0, pan_shift}, 8'h07);
    sync();
    host.wr(ACP_PORT_ATTR_WR, 8'h10);
    px(4'h3, 1'b0, 8'h00);
    done("pixel");
    a = 8'($urandom);
    {glyph_bit, ninth_col, char_code, text_attr} = {2'b10, 8'h41, a};
    wait_dot();
    @(negedge mclk);
    chk("dot_en", {7'h00, dot_en}, 8'h00);
    @(negedge mclk);
    chk("dot_en", {7'h00, dot_en}, 8'h01);
    wi(8'h32, 8'h0f);
    wi(8'h30, 8'h41);
    px8(b, a[3:0]);
    wi(8'h30, 8'h08);
    px(4'h0, 1'b0, {c[3:2], pal[a[3:0]]});
    glyph_bit = 1'b0;
    px(4'h0, 1'b0, {c[3:2], pal[{1'b0, a[6:4]}]});
    vsync_pulse = 1'b1;
    @(negedge mclk);
    vsync_pulse = 1'b0;
    glyph_bit = 1'b1;
    text_attr = a | 8'h80;
    px(4'h0, 1'b0, {c[3:2], pal[{1'b0, a[6:4]}]});
    wi(8'h30, 8'h09);
    px(4'hf, 1'b0, {c[3:2], pal[7]});
    wi(8'h30, 8'h06);
    px(4'h0, 1'b0, {c[3:2], pal[{a[3], 3'b111}]});
    {glyph_bit, ninth_col, char_code} = {2'b01, 8'hc4};
    px(4'h0, 1'b0, {c[3:2], pal[{a[3], 3'b111}]});
    char_code = 8'h41;
    px(4'h0, 1'b0, {c[3:2], pal[0]});
    // reset in mid-run while the shared port waits for data
    sync();
    host.wr(ACP_PORT_ATTR_WR, 8'h13);
    @(negedge mclk);
    resetn = 1'b0;
    @(negedge mclk);
    resetn = 1'b1;
    host.wr(ACP_PORT_ATTR_WR, 8'h11);
    rq.push_back(8'h11);
    host.rd(ACP_PORT_ATTR_WR);
    done("text");
    summarize();
  end
endmodule
